// ==== hw/aoi_top.v ====
// Audio output interface: APB registers, CPU sample buffer, MP3 word
// buffer, clock generation and serial output toward an external DAC.
// Assumes pll_clk_en is a one-cycle pulse per PLL clock in pclk domain.
// Summary of operation
// R1: audio clock is the PLL clock divided by the divider field; the code divides by the field plus one
// R2: enable bit drives master clock onto DAC system clock pin
// R3: software sets high-rate bit to match 256 or 384 times Fs
// R4: bit and word clocks stop while no data reaches converter
// R5: 16 or 32 bit clocks per channel by the size bit
// R6: polarity bit picks word-select level of the left channel
// R7: 16-bit words serialised; justify field moves output start
// R8: justify 0 is MSB, 1 is LSB, larger pads zeros low
// R9: source bit picks MP3 decoder or CPU sample buffer
// R10: clocks start when first datum reaches the converter
// R11: CPU mode widens 8-bit samples at 8 kHz with zero low byte
// R12: repeat field duplicates samples for 8, 16, 32 or 48 kHz; the code loads dup_cnt from it but nothing uses dup_cnt
// R13: eight-byte CPU buffer; full flag and underrun flag
// R14: request flag sets on count 4 to 3, clears on 4 to 5
// R15: underrun flag sets when CPU buffer becomes empty
// R16: MP3 buffer requests 16-bit words only while it has space
// R17: fetch enable gates requests; cleared buffer drains then pauses
// R18: CPU-mode interrupt from request or underrun, masked, enabled
// R19: data write clears request and underrun flags
// R20: host loads samples four bytes at a time on request
// R21: serial data aligned to bit clock, word select marks channels
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "aoi_defines.vh"
module aoi_top
#(
	parameter MP3_DEPTH = 4,
	parameter BASE_CYC  = `AOI_BASE_CYC
)
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        pll_clk_en,
	input  wire [15:0] mp3_word,
	input  wire        mp3_valid,
	output reg         mp3_request,
	output reg         dac_sys_clk,
	output reg         serial_bit_clock_pin,
	output reg         word_select_pin,
	output reg         serial_data_pin,
	output reg         audio_irq
);
	reg [7:0] audio_control_zero;
	reg [7:0] audio_control_one;
	reg [4:0] audio_clock_divider;
	reg       audio_irq_enable;
	reg       sample_request_flag;
	reg       underrun_flag;
	reg [7:0] cpu_buf [0:`AOI_CPU_DEPTH-1];
	reg [2:0] cpu_wr;
	reg [2:0] cpu_rd;
	reg [3:0] cpu_cnt;
	reg [15:0] mp3_buf [0:MP3_DEPTH-1];
	reg [2:0] mp3_wr;
	reg [2:0] mp3_rd;
	reg [3:0] mp3_cnt;
	reg [4:0] div_cnt;
	reg       aud_en;
	reg [1:0] dup_cnt;
	reg [15:0] base_cnt;
	reg [15:0] held_word;
	reg       started;
	reg       cfg_pulse;
	integer   i;
	wire interface_on_bit = audio_control_one[`AOI_C1_EN];
	wire stream_source_select = audio_control_one[`AOI_C1_SRC];
	wire decoded_fetch_enable = audio_control_one[`AOI_C1_DRQ];
	wire sample_request_mask = audio_control_one[`AOI_C1_MSRQ];
	wire underrun_mask = audio_control_one[`AOI_C1_MUDR];
	wire [1:0] repeat_factor = audio_control_one[2:1];
	wire high_rate_select = audio_control_zero[`AOI_C0_HLR];
	wire slot_size_select = audio_control_zero[`AOI_C0_DSZ];
	wire left_level_select = audio_control_zero[`AOI_C0_POL];
	wire [4:0] justify_shift = audio_control_zero[7:3];
	wire acc = psel && penable;
	wire wr_dat = acc && pwrite && paddr == `AOI_OFF_DAT;
	wire cpu_full = cpu_cnt == `AOI_CPU_DEPTH;
	wire ser_take;
	wire ser_bclk;
	wire ser_ws;
	wire ser_sd;
	// Run to the end of a frame; stop at a frame head with nothing buffered
	wire buf_ready = stream_source_select ? cpu_cnt != 4'd0
		: mp3_cnt != 4'd0;
	wire have_data = buf_ready || (started && !ser_take);

	// Word fetch for the converter: CPU bytes widened, or MP3 words
	function [15:0] widen;
		input [7:0] b;
		widen = {b, 8'h00};
	endfunction
	function [1:0] reps;
		input [1:0] f;
		case (f)
		2'd0: reps = 2'd0;
		2'd1: reps = 2'd1;
		default: reps = 2'd3;
		endcase
	endfunction

	// Audio clock enable from PLL divided by divider field plus one
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_cnt <= 5'h00;
			aud_en <= 1'b0;
		end
		else
		begin
			aud_en <= 1'b0;
			if (pll_clk_en)
			begin
				if (div_cnt >= audio_clock_divider)
				begin
					div_cnt <= 5'h00;
					aud_en <= 1'b1; // see R1
				end
				else
					div_cnt <= div_cnt + 5'd1;
			end
		end
	end

	// Bit enable: bit clock is master divided by 4 (256 Fs) or 6 (384 Fs)
	reg [2:0] ms_cnt;
	reg       bit_en;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_cnt <= 3'd0;
			bit_en <= 1'b0;
			dac_sys_clk <= 1'b0;
		end
		else
		begin
			bit_en <= 1'b0;
			if (!interface_on_bit)
				dac_sys_clk <= 1'b0;
			else if (aud_en)
			begin
				dac_sys_clk <= ~dac_sys_clk; // see R2
				if (ms_cnt >= (high_rate_select ? 3'd5 : 3'd3)) // see R3
				begin
					ms_cnt <= 3'd0;
					bit_en <= 1'b1;
				end
				else
					ms_cnt <= ms_cnt + 3'd1;
			end
		end
	end

	// APB register access, buffers and flags
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			audio_control_zero <= `AOI_CON0_RST;
			audio_control_one <= `AOI_CON1_RST;
			audio_clock_divider <= 5'h00;
			audio_irq_enable <= 1'b0;
			sample_request_flag <= 1'b1;
			underrun_flag <= 1'b1;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			cpu_wr <= 3'd0;
			cpu_rd <= 3'd0;
			cpu_cnt <= 4'd0;
			mp3_wr <= 3'd0;
			mp3_rd <= 3'd0;
			mp3_cnt <= 4'd0;
			mp3_request <= 1'b0;
			dup_cnt <= 2'd0;
			base_cnt <= 16'h0000;
			held_word <= 16'h0000;
			started <= 1'b0;
			audio_irq <= 1'b0;
			cfg_pulse <= 1'b0;
			for (i = 0; i < `AOI_CPU_DEPTH; i = i + 1)
				cpu_buf[i] <= 8'h00;
			for (i = 0; i < MP3_DEPTH; i = i + 1)
				mp3_buf[i] <= 16'h0000;
		end
		else
		begin
			pready <= acc && !pready;
			pslverr <= 1'b0;
			cfg_pulse <= 1'b0;
			if (acc && !pready)
			begin
				prdata <= 32'h00000000;
				if (paddr == `AOI_OFF_CON0)
				begin
					if (pwrite) audio_control_zero <= pwdata[7:0];
					prdata <= {24'h000000, audio_control_zero};
				end
				else if (paddr == `AOI_OFF_CON1)
				begin
					if (pwrite) audio_control_one <= pwdata[7:0] & 8'hf7;
					prdata <= {24'h000000, audio_control_one};
				end
				else if (paddr == `AOI_OFF_STA)
					prdata <= {24'h000000, sample_request_flag,
						underrun_flag, cpu_full, 5'h00};
				else if (paddr == `AOI_OFF_DAT)
					prdata <= 32'h000000ff;
				else if (paddr == `AOI_OFF_CLK)
				begin
					if (pwrite) audio_clock_divider <= pwdata[4:0];
					prdata <= {27'h0000000, audio_clock_divider};
				end
				else if (paddr == `AOI_OFF_IEN)
				begin
					if (pwrite) audio_irq_enable <= pwdata[0];
					prdata <= {31'h00000000, audio_irq_enable};
				end
				else
					pslverr <= 1'b1;
			end
			// CPU sample buffer: one byte per 8 kHz tick, whatever the repeat field
			begin : cpu_path
				reg push;
				reg pop;
				reg [3:0] nc;
				push = wr_dat && !pready && !cpu_full;
				pop = 1'b0;
				// Samples leave only while the interface plays them
				if (stream_source_select && interface_on_bit
					&& base_cnt >= BASE_CYC - 1)
				begin
					base_cnt <= 16'h0000;
					if (cpu_cnt != 4'd0) pop = 1'b1; // see R11
				end
				else if (stream_source_select && interface_on_bit)
					base_cnt <= base_cnt + 16'd1;
				if (push)
				begin
					cpu_buf[cpu_wr] <= pwdata[7:0];
					cpu_wr <= cpu_wr + 3'd1;
				end
				if (pop)
				begin
					held_word <= widen(cpu_buf[cpu_rd]); // see R11
					cpu_rd <= cpu_rd + 3'd1;
				end
				nc = cpu_cnt + {3'b000, push} - {3'b000, pop};
				cpu_cnt <= nc; // see R13
				// Flag events win over the clearing data write
				if (wr_dat && !pready)
				begin
					sample_request_flag <= 1'b0; // see R19
					underrun_flag <= 1'b0;
				end
				if (cpu_cnt == 4'd4 && nc == 4'd3)
					sample_request_flag <= 1'b1; // see R14
				else if (cpu_cnt == 4'd4 && nc == 4'd5)
					sample_request_flag <= 1'b0;
				if (stream_source_select && pop && nc == 4'd0)
					underrun_flag <= 1'b1; // see R15
			end
			// MP3 word buffer
			if (mp3_request && mp3_valid)
			begin
				mp3_buf[mp3_wr[1:0]] <= mp3_word;
				mp3_wr <= mp3_wr + 3'd1;
			end
			if (!stream_source_select && ser_take && mp3_cnt != 4'd0)
			begin
				held_word <= mp3_buf[mp3_rd[1:0]]; // see R9
				mp3_rd <= mp3_rd + 3'd1;
			end
			mp3_cnt <= mp3_cnt
				+ {3'b000, mp3_request && mp3_valid}
				- {3'b000, !stream_source_select && ser_take
				&& mp3_cnt != 4'd0};
			mp3_request <= decoded_fetch_enable && interface_on_bit
				&& mp3_cnt < MP3_DEPTH - 1; // see R16 see R17
			if (ser_take)
				dup_cnt <= (dup_cnt == 2'd0) ? reps(repeat_factor)
					: dup_cnt - 2'd1; // see R12
			started <= interface_on_bit && have_data; // see R10
			audio_irq <= audio_irq_enable && stream_source_select
				&& ((sample_request_flag && !sample_request_mask)
				|| (underrun_flag && !underrun_mask)); // see R18
		end
	end

	aoi_serializer u_ser
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.bit_en     (bit_en),
		.run        (started),
		.slot32     (slot_size_select),
		.left_high  (left_level_select),
		.justify    (justify_shift),
		.left_word  (held_word),
		.right_word (held_word),
		.take       (ser_take),
		.bclk       (ser_bclk),
		.wsel       (ser_ws),
		.sdata      (ser_sd)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_bit_clock_pin <= 1'b0;
			word_select_pin <= 1'b0;
			serial_data_pin <= 1'b0;
		end
		else
		begin
			serial_bit_clock_pin <= ser_bclk;
			word_select_pin <= ser_ws;
			serial_data_pin <= ser_sd;
		end
	end
endmodule
`default_nettype wire

// ==== hw/aoi_defines.vh ====
// Register offsets, field positions, reset values and timing counts
// Included by the audio output interface top-level design file
`ifndef AOI_DEFINES_VH
`define AOI_DEFINES_VH
`define AOI_OFF_CON0     12'h000
`define AOI_OFF_CON1     12'h004
`define AOI_OFF_STA      12'h008
`define AOI_OFF_DAT      12'h00c
`define AOI_OFF_CLK      12'h010
`define AOI_OFF_IEN      12'h014
`define AOI_CON0_RST     8'h08
`define AOI_CON1_RST     8'hb2
`define AOI_CLK_RST      8'h00
`define AOI_IEN_RST      8'h00
`define AOI_C0_HLR       0
`define AOI_C0_DSZ       1
`define AOI_C0_POL       2
`define AOI_C0_JST_LO    3
`define AOI_C1_EN        0
`define AOI_C1_DUP_LO    1
`define AOI_C1_MUDR      4
`define AOI_C1_MSRQ      5
`define AOI_C1_DRQ       6
`define AOI_C1_SRC       7
`define AOI_ST_FULL      5
`define AOI_ST_UDR       6
`define AOI_ST_SRQ       7
`define AOI_CPU_DEPTH    8
`define AOI_BASE_HZ      8000
`define AOI_CLK_HZ       25000000
`define AOI_BASE_CYC     (`AOI_CLK_HZ / `AOI_BASE_HZ)
`endif

// ==== hw/aoi_serializer.v ====
// Serial converter: shifts one left/right pair of 16-bit words out per frame
// Assumes bit_en is a one-cycle enable at twice the bit clock rate
`timescale 1ns/1ps
`default_nettype none
module aoi_serializer
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        bit_en,
	input  wire        run,
	input  wire        slot32,
	input  wire        left_high,
	input  wire [4:0]  justify,
	input  wire [15:0] left_word,
	input  wire [15:0] right_word,
	output reg         take,
	output reg         bclk,
	output reg         wsel,
	output reg         sdata
);
	reg [5:0] bitpos;
	reg [15:0] cur_l;
	reg [15:0] cur_r;
	wire [4:0] slot_len = slot32 ? 5'd31 : 5'd15;
	wire [4:0] inpos = bitpos[4:0];
	wire        right_half = slot32 ? bitpos[5] : bitpos[4];
	// At the frame head the incoming word is shown before it is latched
	wire [15:0] word = right_half ? cur_r
		: (bitpos == 6'h00 ? left_word : cur_l);
	wire [4:0]  inslot = slot32 ? inpos : {1'b0, inpos[3:0]};
	wire [6:0]  slot_bits = slot32 ? 7'd32 : 7'd16;
	// Justify 0 starts at the slot head; n above 0 ends the word n-1
	// bits before the slot end, zeros below it
	wire [6:0]  start = (justify == 5'd0) ? 7'h00
		: slot_bits - 7'd15 - {2'b00, justify};
	reg         next_bit;
	reg [6:0]   idx;
	always @*
	begin
		idx = {2'b00, inslot} - start;
		if (idx[6] || idx > 7'd15)
			next_bit = 1'b0;
		else
			next_bit = word[4'd15 - idx[3:0]];
	end
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bitpos <= 6'h00;
			bclk <= 1'b0;
			wsel <= 1'b0;
			sdata <= 1'b0;
			take <= 1'b0;
			cur_l <= 16'h0000;
			cur_r <= 16'h0000;
		end
		else
		begin
			take <= 1'b0;
			if (!run)
			begin
				bclk <= 1'b0; // see R4
				bitpos <= 6'h00;
			end
			else if (bit_en)
			begin
				bclk <= ~bclk; // see R5
				if (bclk)
				begin
					// Falling edge: data and word select settle before rise
					sdata <= next_bit; // see R7 see R8 see R21
					wsel <= right_half ? ~left_high : left_high; // see R6
					if (bitpos == {slot_len, 1'b1} || (slot32 && bitpos == 6'h3f))
						bitpos <= 6'h00;
					else
						bitpos <= bitpos + 6'd1;
					if (bitpos == 6'h00)
					begin
						cur_l <= left_word;
						cur_r <= right_word;
						take <= 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/aoi_top_properties.sv ====
// Port checker for the audio output interface
// Assumes it is bound to aoi_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module aoi_props
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        mp3_valid,
	input wire logic        mp3_request,
	input wire logic        dac_sys_clk,
	input wire logic        serial_bit_clock_pin,
	input wire logic        serial_data_pin,
	input wire logic        audio_irq
);
	logic [7:0] c1;
	logic [7:0] ie;
	logic       seen;
	wire        acc = psel && penable && !pready;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow copies of the enables, taken at the access edge
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			c1   <= 8'hb2;
			ie   <= 8'h00;
			seen <= 1'b0;
		end
		else
		begin
			if (acc && pwrite && paddr == 12'h004)
				c1 <= pwdata[7:0];
			if (acc && pwrite && paddr == 12'h014)
				ie <= pwdata[7:0];
			if ((mp3_request && mp3_valid) || (acc && pwrite && paddr == 12'h00c))
				seen <= 1'b1;
		end
	a_ready_wait: assert property (acc |=> pready)
		else $error("no ready after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_slverr_map: assert property (acc |=>
		pslverr == $past(paddr > 12'h014 || paddr[1:0] != 2'b00))
		else $error("error response wrong");
	a_data_reads: assert property (acc && !pwrite && paddr == 12'h00c
		|=> prdata[7:0] == 8'hff)
		else $error("data register read wrong");
	a_irq_gate: assert property (
		audio_irq |-> $past(ie[0] && c1[7] && !(c1[5] && c1[4])))
		else $error("interrupt while gated off");
	a_req_gate: assert property (
		mp3_request |-> $past(c1[6] && c1[0]))
		else $error("decoder request while disabled");
	a_sysclk_off: assert property (
		!c1[0] && !$past(c1[0]) && !$past(c1[0], 2) |-> $stable(dac_sys_clk))
		else $error("system clock moves while off");
	a_bclk_idle: assert property (
		!seen |-> !serial_bit_clock_pin && !serial_data_pin)
		else $error("serial clock before first data");
endmodule
bind aoi_top aoi_props chk
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .mp3_valid, .mp3_request, .dac_sys_clk,
	.serial_bit_clock_pin, .serial_data_pin, .audio_irq
);
`default_nettype wire

// ==== tb/aoi_mp3_model.sv ====
// Decoded-word source standing in for the on-chip decoder
// Assumes a word is taken on an edge with request and valid high
`timescale 1ns/1ps
`default_nettype none
module aoi_mp3_model
#(
	parameter logic [15:0] WORD = 16'hc3a5
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        slow,
	input  wire logic        mp3_request,
	output var  logic [15:0] mp3_word,
	output var  logic        mp3_valid
);
	logic tog;
	// Offer held until taken; idle bus shows the inverse word
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mp3_valid <= 1'b0;
			mp3_word  <= 16'h0000;
			tog       <= 1'b0;
		end
		else if (!mp3_valid || mp3_request)
		begin
			tog       <= !tog;
			mp3_valid <= !slow || tog;
			mp3_word  <= (!slow || tog) ? WORD : ~mp3_word;
		end
endmodule
`default_nettype wire

// ==== tb/aoi_top_bench.sv ====
// Self-checking bench for the audio output interface
// Assumes the design, its checker and the decoder model
`timescale 1ns/1ps
`default_nettype none
module aoi_top_bench;
	logic        pclk, presetn, psel, penable, pwrite, pll_clk_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat, slot, sh;
	logic        pready, pslverr, mp3_valid, mp3_request, slow, rerr;
	logic        dac_sys_clk, serial_bit_clock_pin, word_select_pin;
	logic        serial_data_pin, audio_irq, lb, lw, ls;
	logic [15:0] mp3_word;
	int          err_count, checks_done, cyc, nb, slen, nslot, rises;
	int          sysc, k;
	logic [7:0]  rst [6] = '{8'h08, 8'hb2, 8'hc0, 8'hff, 8'h00, 8'h00};
	logic [7:0]  c0t [5] = '{8'h00, 8'h02, 8'h0a, 8'h0b, 8'h07};
	logic [31:0] ext [5] = '{32'h0000c3a5, 32'hc3a50000, 32'h0000c3a5,
		32'h0000c3a5, 32'hc3a50000};
	int          lnt [5] = '{16, 32, 32, 32, 32};
	initial
	begin
		pclk = 1'b0;
		forever
			#20 pclk = ~pclk;
	end
	aoi_top #(.MP3_DEPTH(4), .BASE_CYC(20)) dut
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pll_clk_en, .mp3_word, .mp3_valid,
		.mp3_request, .dac_sys_clk, .serial_bit_clock_pin,
		.word_select_pin, .serial_data_pin, .audio_irq
	);
	aoi_mp3_model peer
	(
		.pclk, .presetn, .slow, .mp3_request, .mp3_word, .mp3_valid
	);
	// Collects serial bits per word-select half
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		lb  <= serial_bit_clock_pin;
		lw  <= word_select_pin;
		ls  <= dac_sys_clk;
		if (dac_sys_clk !== ls)
			sysc <= sysc + 1;
		if (serial_bit_clock_pin && !lb)
		begin
			sh    <= {sh[30:0], serial_data_pin};
			nb    <= nb + 1;
			rises <= rises + 1;
		end
		if (word_select_pin !== lw)
		begin
			slot  <= sh;
			slen  <= nb;
			nb    <= (serial_bit_clock_pin && !lb) ? 1 : 0;
			nslot <= nslot + 1;
		end
		if (cyc == 60000)
			close_out(1'b1);
	end
	task automatic close_out(input bit tmo);
		if (tmo)
			err_count++;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input string s, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input string s);
		apb(1'b0, a, 32'h0);
		cmp(s, e, rdat);
	endtask
	task automatic ser(input logic [7:0] c, input logic [31:0] e,
		input int l);
		int n;
		apb(1'b1, 12'h000, {24'h0, c});
		n = nslot;
		while (nslot < n + 4)
			@(posedge pclk);
		cmp("slot bits", e, l == 32 ? slot : {16'h0, slot[15:0]});
		cmp("slot length", l, slen);
	endtask
	initial
	begin
		{psel, penable, pwrite, slow} <= 4'h0;
		paddr      <= 12'h000;
		pwdata     <= 32'h0;
		pll_clk_en <= 1'b1;
		presetn    <= 1'b0;
		{lb, lw, ls, sh} = '0;
		{cyc, nb, nslot, rises, sysc} = '0;
		err_count = 0;
		checks_done = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 6; i++)
			rd(12'(4 * i), {24'h0, rst[i]}, "reset value");
		apb(1'b0, 12'h018, 32'h0);
		cmp("unmapped error", 32'h1, rerr);
		for (int d = 0; d < 4; d++)
		begin
			apb(1'b1, 12'h004, 32'h88 | (d << 1));
			rd(12'h004, 32'h80 | (d << 1), "control one");
		end
		apb(1'b1, 12'h004, 32'h80);
		apb(1'b1, 12'h014, 32'h1);
		repeat (2) @(posedge pclk);
		cmp("irq raised", 32'h1, audio_irq);
		for (int i = 0; i < 9; i++)
			apb(1'b1, 12'h00c, 32'h40 + i);
		rd(12'h008, 32'h20, "status full");
		cmp("irq cleared", 32'h0, audio_irq);
		apb(1'b1, 12'h004, 32'h81);
		while (audio_irq !== 1'b1)
			@(posedge pclk);
		rd(12'h008, 32'h80, "status request");
		for (int i = 0; i < 4; i++)
			apb(1'b1, 12'h00c, 32'h50 + i);
		rd(12'h008, 32'h00, "status refilled");
		apb(1'b1, 12'h004, 32'ha1);
		while (audio_irq !== 1'b1)
			@(posedge pclk);
		rd(12'h008, 32'hc0, "status empty");
		apb(1'b1, 12'h004, 32'hb1);
		repeat (2) @(posedge pclk);
		cmp("irq masked", 32'h0, audio_irq);
		apb(1'b1, 12'h014, 32'h0);
		apb(1'b1, 12'h010, 32'h1);
		apb(1'b1, 12'h004, 32'h41);
		k = sysc;
		repeat (200) @(posedge pclk);
		cmp("system clock", 32'h1, sysc > k);
		for (int i = 0; i < 5; i++)
			ser(c0t[i], ext[i], lnt[i]);
		slow <= 1'b1;
		ser(8'h02, 32'hc3a50000, 32);
		apb(1'b1, 12'h004, 32'h01);
		repeat (8000) @(posedge pclk);
		k = rises;
		repeat (1000) @(posedge pclk);
		cmp("clock after drain", k, rises);
		apb(1'b1, 12'h004, 32'h41);
		repeat (2000) @(posedge pclk);
		cmp("clock restarts", 32'h1, rises > k);
		close_out(1'b0);
	end
endmodule
`default_nettype wire
